// >>> usi_pkg.sv
// Constants shared by the USB status interrupt logic.
package usi_pkg;
  // Register offsets on the plain register port.
  localparam logic [2:0] USI_OFS_FLAGS = 3'h0;
  localparam logic [2:0] USI_OFS_ENABLES = 3'h1;
  localparam logic [2:0] USI_OFS_ERR_FLAGS = 3'h2;
  localparam logic [2:0] USI_OFS_ERR_ENABLES = 3'h3;
  localparam logic [2:0] USI_OFS_CONTROL = 3'h4;
  localparam logic [2:0] USI_OFS_XACT_STATUS = 3'h5;
  localparam logic [2:0] USI_OFS_FUNC_ADDR = 3'h6;
  // Status flag and enable bit positions.
  localparam int USI_BIT_SOF = 6;
  localparam int USI_BIT_STALL = 5;
  localparam int USI_BIT_IDLE = 4;
  localparam int USI_BIT_XACT = 3;
  localparam int USI_BIT_ACTV = 2;
  localparam int USI_BIT_ERR = 1;
  localparam int USI_BIT_URST = 0;
  // Control register bit that suspends the module.
  localparam int USI_BIT_SUSPEND = 1;
  // Implemented and software-writable bit masks.
  localparam logic [7:0] USI_FLAG_IMPL = 8'h7F;
  localparam logic [7:0] USI_FLAG_SW = 8'h7D;
  localparam logic [7:0] USI_ERR_IMPL = 8'h9F;
  localparam logic [7:0] USI_CTRL_IMPL = 8'h02;
  localparam logic [7:0] USI_FADDR_IMPL = 8'h7F;
  // Reset values.
  localparam logic [7:0] USI_RST_REG = 8'h00;
  localparam logic [7:0] USI_RST_FADDR = 8'h00;
  // Timing.
  localparam int USI_CLK_HZ = 25000000;
  localparam int USI_IDLE_TIME_US = 3000;
  localparam int USI_IDLE_CYCLES = USI_IDLE_TIME_US * (USI_CLK_HZ / 1000000);
  localparam int USI_ACTV_SYNC_CYCLES = 4;
endpackage

// >>> usi_status_irq.sv
// USB status interrupt flags, enables, transaction status queue and request.
//
// Summary of operation
// R1: Interrupt request is OR of every flag gated by its enable.
// R2: Hardware-set flags stay set until software writes zero there.
// R3: Software writing one to a writable flag sets it.
// R4: Bit 7 of flags and enables ignores writes and reads zero.
// R5: Bit 6 flags a received start-of-frame token.
// R6: Bit 5 flags a STALL handshake sent.
// R7: Bit 4 flags bus idle for 3 ms or longer.
// R8: Clearing bit 3 advances the status queue for token transactions.
// R9: Bit 2 flags activity on the data lines.
// R10: Bit 1 is error summary, read-only to software.
// R11: Bit 0 flags bus reset and reloads the function address.
// R12: Activity clear ignored while suspended or shortly after wake.
// R13: Firmware clears suspend, then clears activity until it reads zero.
// R14: Module stays non-operational after wake until the PLL locks.
// R15: Enable bits 6 to 0 match flag positions and gate them.
// R16: Flags still set by events when their enable is low.
// R17: Firmware may suspend the module after idle is flagged.
// R18: Error summary is OR of error flags gated by error enables.
// R19: All sources funnel into one module request output.
// R20: Transaction status records even or odd buffer descriptor.
// R21: All flags and enables reset to zero.
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module usi_status_irq #(
  parameter int IDLE_CYCLES = usi_pkg::USI_IDLE_CYCLES,
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_resetn,
  // Register port.
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [7:0] o_rdata,
  // Serial interface engine events.
  input wire logic i_sof_evt,
  input wire logic i_stall_evt,
  input wire logic i_bus_idle,
  input wire logic i_activity_evt,
  input wire logic i_bus_reset_evt,
  input wire logic [7:0] i_err_evt,
  // Completed transaction report.
  input wire logic i_xact_evt,
  input wire logic i_xact_token,
  input wire logic [3:0] i_xact_endpoint,
  input wire logic i_xact_in,
  input wire logic i_xact_odd,
  // Clock source status.
  input wire logic i_pll_locked,
  // Module outputs.
  output logic o_module_irq_request,
  output logic o_module_ready,
  output logic o_suspended,
  output logic [6:0] o_function_address
);
  import usi_pkg::*;

  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int SYNC_W = $clog2(USI_ACTV_SYNC_CYCLES + 1);
  localparam int IDLE_W = $clog2(IDLE_CYCLES + 1);

  logic [7:0] flags_q, flags_d;
  logic [7:0] enables_q;
  logic [7:0] err_flags_q, err_flags_d;
  logic [7:0] err_enables_q;
  logic [7:0] ctrl_q;
  logic [6:0] faddr_q;
  logic [7:0] rdata_q;
  logic [SYNC_W-1:0] sync_cnt_q;
  logic [IDLE_W-1:0] idle_cnt_q;
  logic idle_hit;
  // Queue entries: endpoint, direction, odd buffer, token transaction.
  logic [6:0] fifo_mem [FIFO_DEPTH];
  logic [PW-1:0] rd_ptr_q, wr_ptr_q;
  logic [PW:0] count_q;

  wire wr_flags = i_write && (i_addr == USI_OFS_FLAGS);
  wire wr_enables = i_write && (i_addr == USI_OFS_ENABLES);
  wire wr_err_flags = i_write && (i_addr == USI_OFS_ERR_FLAGS);
  wire wr_err_enables = i_write && (i_addr == USI_OFS_ERR_ENABLES);
  wire wr_ctrl = i_write && (i_addr == USI_OFS_CONTROL);
  wire wr_faddr = i_write && (i_addr == USI_OFS_FUNC_ADDR);
  wire suspended = ctrl_q[USI_BIT_SUSPEND];

  // A wake leaves the activity logic unsynchronised for a few cycles and
  // until the PLL locks, so a clear in that window has no effect.
  wire actv_clr_ok = !suspended && i_pll_locked && (sync_cnt_q == '0); // R12 R14
  wire ready = actv_clr_ok; // R14

  wire fifo_empty = (count_q == '0);
  wire fifo_full = (count_q == (PW+1)'(FIFO_DEPTH));
  wire [6:0] fifo_head = fifo_mem[rd_ptr_q];
  wire xact_clear = wr_flags && flags_q[USI_BIT_XACT] && !i_wdata[USI_BIT_XACT];
  wire fifo_pop = xact_clear && !fifo_empty && fifo_head[0]; // R8
  // A push into a full queue is dropped unless a pop happens in the same cycle; the engine must not report more
  // transactions than the queue holds while the flag is pending.
  wire fifo_push = i_xact_evt && (!fifo_full || fifo_pop);
  wire more_left = fifo_pop && (count_q > (PW+1)'(1));

  wire err_summary = |(err_flags_q & err_enables_q & USI_ERR_IMPL); // R18 R10

  wire [7:0] hw_set = {1'b0, i_sof_evt, i_stall_evt, idle_hit, // R5 R6 R7
    i_xact_evt | more_left, i_activity_evt, err_summary, i_bus_reset_evt}; // R9 R11

  // Software write result before hardware events are merged.
  wire [7:0] sw_keep = actv_clr_ok ? ~USI_FLAG_SW : (~USI_FLAG_SW | 8'h04);
  wire [7:0] sw_flags = (i_wdata & USI_FLAG_SW) | (flags_q & sw_keep); // R2 R3

  always_comb
  begin
    flags_d = wr_flags ? sw_flags : flags_q;
    flags_d[USI_BIT_ERR] = err_summary; // R10
    flags_d = (flags_d | hw_set) & USI_FLAG_IMPL; // R2 R4 R16
    err_flags_d = wr_err_flags ? (err_flags_q & i_wdata) : err_flags_q;
    err_flags_d = (err_flags_d | i_err_evt) & USI_ERR_IMPL;
  end

  assign idle_hit = i_bus_idle && (idle_cnt_q == IDLE_W'(IDLE_CYCLES - 1)); // R7

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      flags_q <= USI_RST_REG; // R21
      enables_q <= USI_RST_REG; // R21
      err_flags_q <= USI_RST_REG;
      err_enables_q <= USI_RST_REG;
      ctrl_q <= USI_RST_REG;
    end
    else
    begin
      flags_q <= flags_d;
      err_flags_q <= err_flags_d;
      if (wr_enables)
        enables_q <= i_wdata & USI_FLAG_IMPL; // R4 R15
      if (wr_err_enables)
        err_enables_q <= i_wdata & USI_ERR_IMPL;
      if (wr_ctrl)
        ctrl_q <= i_wdata & USI_CTRL_IMPL;
    end
  end

  // Function address: software writes it, a bus reset reloads zero.
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
      faddr_q <= USI_RST_FADDR[6:0];
    else if (i_bus_reset_evt)
      faddr_q <= USI_RST_FADDR[6:0]; // R11
    else if (wr_faddr)
      faddr_q <= i_wdata[6:0] & USI_FADDR_IMPL[6:0];
  end

  // Synchronisation window after leaving suspend.
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
      sync_cnt_q <= '0;
    else if (suspended)
      sync_cnt_q <= SYNC_W'(USI_ACTV_SYNC_CYCLES); // R12
    else if (sync_cnt_q != '0)
      sync_cnt_q <= sync_cnt_q - SYNC_W'(1);
  end

  // The idle flag fires once per continuous idle stretch.
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
      idle_cnt_q <= '0;
    else if (!i_bus_idle)
      idle_cnt_q <= '0;
    else if (idle_cnt_q != IDLE_W'(IDLE_CYCLES))
      idle_cnt_q <= idle_cnt_q + IDLE_W'(1); // R7
  end

  // Transaction status queue.
  always_ff @(posedge i_clock)
  begin
    if (fifo_push)
      fifo_mem[wr_ptr_q] <= {i_xact_endpoint, i_xact_in, i_xact_odd, i_xact_token}; // R20
  end

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rd_ptr_q <= '0;
      wr_ptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (fifo_push)
        wr_ptr_q <= PW'((wr_ptr_q + 1'b1) % FIFO_DEPTH);
      if (fifo_pop)
        rd_ptr_q <= PW'((rd_ptr_q + 1'b1) % FIFO_DEPTH); // R8
      if (fifo_push && !fifo_pop)
        count_q <= count_q + (PW+1)'(1);
      else if (fifo_pop && !fifo_push)
        count_q <= count_q - (PW+1)'(1);
    end
  end

  // Read mux; unmapped offsets read zero.
  wire [7:0] xact_status = fifo_empty ? 8'h00 : {1'b0, fifo_head[6:1], 1'b0};
  logic [7:0] rd_mux;
  always_comb
  begin
    unique case (i_addr)
      USI_OFS_FLAGS: rd_mux = flags_q;
      USI_OFS_ENABLES: rd_mux = enables_q;
      USI_OFS_ERR_FLAGS: rd_mux = err_flags_q;
      USI_OFS_ERR_ENABLES: rd_mux = err_enables_q;
      USI_OFS_CONTROL: rd_mux = ctrl_q;
      USI_OFS_XACT_STATUS: rd_mux = xact_status;
      USI_OFS_FUNC_ADDR: rd_mux = {1'b0, faddr_q};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
      rdata_q <= 8'h00;
    else if (i_read)
      rdata_q <= rd_mux;
    else
      rdata_q <= 8'h00;
  end

  assign o_rdata = rdata_q;
  assign o_module_irq_request = |(flags_q & enables_q & USI_FLAG_IMPL); // R1 R15 R19
  assign o_module_ready = ready;
  assign o_suspended = suspended;
  assign o_function_address = faddr_q;
endmodule
`default_nettype wire

// >>> usi_status_irq_monitor.sv
// Port-level assertions for the status interrupt block.
`timescale 1ns/100ps
`default_nettype none
module usi_status_irq_chk
  import usi_pkg::*;
(
  // Clock, reset and bus.
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  input wire logic [7:0] o_rdata,
  // Events and outputs.
  input wire logic i_sof_evt,
  input wire logic i_stall_evt,
  input wire logic i_bus_reset_evt,
  input wire logic o_module_irq_request,
  input wire logic [6:0] o_function_address
);
  logic [7:0] en_q;
  // Shadow of the enable register, since the checker cannot see inside.
  always_ff @(posedge i_clock or negedge i_resetn)
    if (!i_resetn)
      en_q <= 8'h00;
    else if (i_write && i_addr == USI_OFS_ENABLES)
      en_q <= i_wdata & USI_FLAG_IMPL;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  sequence s_rd_en;
    i_read && i_addr == USI_OFS_ENABLES;
  endsequence
  AST_EN_READ: assert property (s_rd_en |=> o_rdata == $past(en_q))
    else $error("enable readback");
  AST_NO_EN: assert property (en_q == 8'h00 |-> !o_module_irq_request)
    else $error("irq without enable");
  AST_SOF: assert property (i_sof_evt ##1 en_q[6] |-> o_module_irq_request)
    else $error("sof irq");
  AST_STALL: assert property (i_stall_evt ##1 en_q[5] |-> o_module_irq_request)
    else $error("stall irq");
  AST_URST: assert property (i_bus_reset_evt ##1 en_q[0] |-> o_module_irq_request)
    else $error("bus reset irq");
  AST_FADDR: assert property (i_bus_reset_evt |=> o_function_address == 7'h00)
    else $error("address reload");
  AST_BIT7: assert property (i_read && i_addr <= USI_OFS_ENABLES |=> !o_rdata[7])
    else $error("bit 7 set");
  AST_RST_ZERO: assert property ($rose(i_resetn) |-> !o_module_irq_request)
    else $error("irq after reset");
endmodule
bind usi_status_irq usi_status_irq_chk u_chk (.i_clock(i_clock), .i_resetn(i_resetn),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read),
  .o_rdata(o_rdata), .i_sof_evt(i_sof_evt), .i_stall_evt(i_stall_evt),
  .i_bus_reset_evt(i_bus_reset_evt), .o_module_irq_request(o_module_irq_request),
  .o_function_address(o_function_address));
`default_nettype wire

// >>> usi_sie_model.sv
// Behavioural serial engine that pulses one bus event per command.
`timescale 1ns/100ps
`default_nettype none
module usi_sie_model (
  // Clock and command.
  input wire logic i_clock,
  input wire logic i_fire,
  input wire logic [1:0] i_kind,
  // Event pulses: sof, stall, activity, bus reset.
  output logic [3:0] o_evt
);
  always_ff @(posedge i_clock)
    o_evt <= i_fire ? 4'h1 << i_kind : 4'h0;
endmodule
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the status interrupt block.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import usi_pkg::*;
  logic i_clock = 1'b0, i_resetn = 1'b0, i_write = 1'b0, i_read = 1'b0, rd_d = 1'b0;
  logic fire = 1'b0, idle = 1'b0, xev = 1'b0, xin = 1'b0, xodd = 1'b0, irq;
  logic [1:0] kind = 2'h0;
  logic [2:0] i_addr = 3'h0;
  logic [3:0] xep = 4'h0, ev4;
  logic [7:0] i_wdata = 8'h00, o_rdata, exp_q[$];
  logic [7:0] err = 8'h00;
  logic pll = 1'b1, ready, susp;
  logic [6:0] faddr;
  logic [31:0] seed = 32'hC6DB05BB;
  int n_errors = 0, check_count = 0;
  usi_sie_model u_sie (.i_clock(i_clock), .i_fire(fire), .i_kind(kind), .o_evt(ev4));
  usi_status_irq #(.IDLE_CYCLES(20)) u_dut (.i_clock(i_clock), .i_resetn(i_resetn),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read),
    .o_rdata(o_rdata), .i_sof_evt(ev4[0]), .i_stall_evt(ev4[1]), .i_bus_idle(idle),
    .i_activity_evt(ev4[2]), .i_bus_reset_evt(ev4[3]), .i_err_evt(err),
    .i_xact_evt(xev), .i_xact_token(1'b1), .i_xact_endpoint(xep), .i_xact_in(xin),
    .i_xact_odd(xodd), .i_pll_locked(pll), .o_module_irq_request(irq),
    .o_module_ready(ready), .o_suspended(susp), .o_function_address(faddr));
  initial
    forever #20 i_clock = ~i_clock;
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // Each access holds one extra cycle so a strobe is never set and cleared at one edge.
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
    if (!w)
      exp_q.push_back(d);
    i_addr <= a;
    i_wdata <= d;
    i_write <= w;
    i_read <= !w;
    @(posedge i_clock);
    i_write <= 1'b0;
    i_read <= 1'b0;
    @(posedge i_clock);
  endtask
  task automatic ev(input logic [1:0] k);
    kind <= k;
    fire <= 1'b1;
    @(posedge i_clock);
    fire <= 1'b0;
    repeat (3) @(posedge i_clock);
  endtask
  always @(posedge i_clock)
  begin
    if (rd_d)
      chk("read data", o_rdata, exp_q.pop_front());
    rd_d <= i_read;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #40000;
    n_errors++;
    tally_and_finish;
  end
  initial
  begin
    repeat (16) @(posedge i_clock);
    i_resetn <= 1'b1;
    @(posedge i_clock);
    acc(0, USI_OFS_FLAGS, 8'h00);
    acc(0, USI_OFS_ENABLES, 8'h00);
    seed = xs(seed);
    acc(1, USI_OFS_ENABLES, seed[7:0]);
    acc(0, USI_OFS_ENABLES, seed[7:0] & 8'h7F);
    acc(1, USI_OFS_FLAGS, 8'hFF);
    acc(0, USI_OFS_FLAGS, 8'h7D);
    acc(1, USI_OFS_ENABLES, 8'h00);
    chk("irq", {7'h00, irq}, 8'h00);
    acc(1, USI_OFS_FLAGS, 8'h00);
    acc(0, USI_OFS_FLAGS, 8'h00);
    $display("register access done");
    acc(1, USI_OFS_FUNC_ADDR, 8'h55);
    for (int k = 0; k < 4; k++)
      ev(2'(k));
    acc(0, USI_OFS_FLAGS, 8'h65);
    acc(0, USI_OFS_FUNC_ADDR, 8'h00);
    acc(1, USI_OFS_ENABLES, 8'h20);
    chk("irq", {7'h00, irq}, 8'h01);
    acc(1, USI_OFS_ENABLES, 8'h7F);
    for (int k = 0; k < 4; k++)
      ev(2'(k));
    acc(1, USI_OFS_FLAGS, 8'h00);
    acc(0, USI_OFS_FLAGS, 8'h00);
    $display("event flags done");
    idle <= 1'b1;
    repeat (22) @(posedge i_clock);
    idle <= 1'b0;
    acc(0, USI_OFS_FLAGS, 8'h10);
    {xep, xin, xodd} <= seed[13:8];
    xev <= 1'b1;
    @(posedge i_clock);
    xev <= 1'b0;
    @(posedge i_clock);
    acc(0, USI_OFS_XACT_STATUS, {1'b0, seed[13:8], 1'b0});
    acc(0, USI_OFS_FLAGS, 8'h18);
    acc(1, USI_OFS_FLAGS, 8'h00);
    acc(0, USI_OFS_XACT_STATUS, 8'h00);
    $display("idle and transaction done");
    acc(1, USI_OFS_CONTROL, 8'h02);
    chk("suspended", {7'h00, susp}, 8'h01);
    chk("ready", {7'h00, ready}, 8'h00);
    ev(2'h2);
    acc(1, USI_OFS_FLAGS, 8'h00);
    acc(0, USI_OFS_FLAGS, 8'h04);
    acc(1, USI_OFS_CONTROL, 8'h00);
    repeat (USI_ACTV_SYNC_CYCLES) @(posedge i_clock);
    chk("ready", {7'h00, ready}, 8'h01);
    acc(1, USI_OFS_FLAGS, 8'h00);
    acc(0, USI_OFS_FLAGS, 8'h00);
    pll <= 1'b0;
    ev(2'h2);
    chk("ready", {7'h00, ready}, 8'h00);
    acc(1, USI_OFS_FLAGS, 8'h00);
    acc(0, USI_OFS_FLAGS, 8'h04);
    pll <= 1'b1;
    @(posedge i_clock);
    acc(1, USI_OFS_FLAGS, 8'h00);
    acc(0, USI_OFS_FLAGS, 8'h00);
    $display("suspend clear done");
    acc(1, USI_OFS_ERR_ENABLES, 8'h01);
    err <= 8'h01;
    @(posedge i_clock);
    err <= 8'h00;
    @(posedge i_clock);
    acc(0, USI_OFS_ERR_FLAGS, 8'h01);
    acc(1, USI_OFS_FLAGS, 8'h00);
    acc(0, USI_OFS_FLAGS, 8'h02);
    chk("irq", {7'h00, irq}, 8'h01);
    acc(1, USI_OFS_ERR_FLAGS, 8'h00);
    acc(0, USI_OFS_FLAGS, 8'h00);
    $display("error summary done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
